// ===== src/csbm_pkg.sv
// Constants and types shared by the chip select bus mode sequencer
package csbm_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int CSBM_NUM_CS = 4;
    localparam int CSBM_ADDR_W = 24;
    localparam int CSBM_DATA_W = 8;
    localparam int CSBM_LEN_W = 4;
    localparam int CSBM_MODE_W = 2;
    // ------------------------------------------------------------
    // Per chip select mode encoding, code 3 behaves as native
    // ------------------------------------------------------------
    localparam logic [1:0] CSBM_MODE_NATIVE = 2'h0;
    localparam logic [1:0] CSBM_MODE_THREE = 2'h1;
    localparam logic [1:0] CSBM_MODE_FOUR = 2'h2;
    // ------------------------------------------------------------
    // State length limits in system clock cycles
    // ------------------------------------------------------------
    localparam logic [3:0] CSBM_THREE_MIN_LEN = 4'h1;
    localparam logic [3:0] CSBM_FOUR_MIN_LEN = 4'h2;
    // ------------------------------------------------------------
    // Decode constants and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CSBM_IO_ONCHIP_PAGE = 8'h00;
    localparam logic [3:0] CSBM_RST_CS_N = 4'hf;
    localparam logic [23:0] CSBM_RST_ADDR = 24'h000000;
    localparam logic [7:0] CSBM_RST_DATA = 8'h00;
    localparam logic [3:0] CSBM_RST_CNT = 4'h0;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_TW, ST_T3, ST_T4} csbm_state_t;
endpackage : csbm_pkg

// ===== src/csbm_dec_if.sv
// Address to chip select decode channel between sequencer and decoder
`timescale 1ns/1ps
`default_nettype none
interface csbm_dec_if;
    logic [23:0] addr;
    logic io;
    logic [3:0] hit;
    logic [1:0] idx;
    logic any;
    modport requester (output addr, io, input hit, idx, any);
    modport decoder (input addr, io, output hit, idx, any);
endinterface : csbm_dec_if
`default_nettype wire

// ===== src/csbm_cs_decode.sv
// Priority chip select decoder for memory ranges and I/O pages
`timescale 1ns/1ps
`default_nettype none
module csbm_cs_decode
    import csbm_pkg::*;
(
    csbm_dec_if.decoder dec,
    input wire logic [3:0] cs_en_in,
    input wire logic [3:0] cs_io_in,
    input wire logic [31:0] cs_lower_in,
    input wire logic [31:0] cs_upper_in
);
    // ------------------------------------------------------------
    // Match of one chip select against the address
    // ------------------------------------------------------------
    function automatic logic cs_match(input logic en, input logic io_sel, input logic [7:0] lo,
                                      input logic [7:0] hi, input logic [23:0] a,
                                      input logic is_io);
        logic m;
        m = 1'b0;
        if (en && (io_sel == is_io)) begin
            if (is_io) begin
                // On-chip peripheral page always wins over external I/O
                m = (a[15:8] == lo) && (a[15:8] != CSBM_IO_ONCHIP_PAGE);
            end else begin
                m = (a[23:16] >= lo) && (a[23:16] <= hi);
            end
        end
        return m;
    endfunction : cs_match

    wire logic [3:0] raw;
    genvar g;
    generate
        for (g = 0; g < CSBM_NUM_CS; g++) begin : g_match
            assign raw[g] = cs_match(cs_en_in[g], cs_io_in[g], cs_lower_in[g*8 +: 8],
                                     cs_upper_in[g*8 +: 8], dec.addr, dec.io);
        end
    endgenerate

    // Lower number wins on overlap
    always_comb begin
        dec.hit = 4'h0;
        dec.idx = 2'h0;
        if (raw[0]) begin
            dec.hit = 4'h1;
        end else if (raw[1]) begin
            dec.hit = 4'h2;
            dec.idx = 2'h1;
        end else if (raw[2]) begin
            dec.hit = 4'h4;
            dec.idx = 2'h2;
        end else if (raw[3]) begin
            dec.hit = 4'h8;
            dec.idx = 2'h3;
        end
        dec.any = |raw;
    end
endmodule : csbm_cs_decode
`default_nettype wire

// ===== src/csbm_top.sv
// Chip select bus mode sequencer: native, three-state and four-state latch cycles
//
// Contract
// - On grant, drive acknowledge low and release address and data buses.
// - While granted, decode external address and assert matching chip selects.
// - External master never reaches internal registers during a grant.
// - Each chip select has its own bus format and state length.
// - Native mode passes CPU signals unchanged; native is the reset default.
// - Three-state mode states last 1 to 15 system clocks.
// - Three-state read runs T1 T2 T3; T1 drives address and chip select.
// - Three-state T2 asserts read strobe plus memory or I/O request.
// - Wait low one clock before T2 end inserts waits until high.
// - Three-state read data captured at the edge ending T3.
// - Three-state write: T1 address, T2 write strobe and request, T3 unchanged.
// - Four-state mode offers separate or multiplexed address and data per chip select.
// - Multiplexed four-state cycles put the low address byte on data in T1.
// - Four-state read: T1 address, chip select, latch enable high first half.
// - Four-state T2 asserts read strobe plus memory or I/O request.
// - Four-state ready low before T3 inserts waits until it goes high.
// - Four-state read latches data entering T4, then drops read strobe.
// - Four-state mode states last 2 to 15 system clocks.
`timescale 1ns/1ps
`default_nettype none
module csbm_top
    import csbm_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [7:0] cs_mode_in,
    input wire logic [3:0] cs_mux_in,
    input wire logic [15:0] cs_len_in,
    input wire logic [3:0] cs_en_in,
    input wire logic [3:0] cs_io_in,
    input wire logic [31:0] cs_lower_in,
    input wire logic [31:0] cs_upper_in,
    input wire logic cpu_req_in,
    input wire logic cpu_wr_in,
    input wire logic cpu_io_in,
    input wire logic [23:0] cpu_addr_in,
    input wire logic [7:0] cpu_wdata_in,
    input wire logic cpu_rd_n_in,
    input wire logic cpu_wr_n_in,
    input wire logic cpu_mem_req_n_in,
    input wire logic cpu_io_req_n_in,
    input wire logic wait_n_in,
    input wire logic [7:0] bus_data_in,
    input wire logic bus_grant_request_n_in,
    input wire logic [23:0] ext_addr_in,
    input wire logic ext_mem_req_n_in,
    input wire logic ext_io_req_n_in,
    output logic [23:0] bus_addr_out,
    output logic addr_oe_out,
    output logic [7:0] bus_data_out,
    output logic data_oe_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic memory_request_strobe_n_out,
    output logic io_request_strobe_n_out,
    output logic ale_out,
    output logic [3:0] cs_n_out,
    output logic [7:0] cpu_rdata_out,
    output logic cpu_done_out,
    output logic cpu_busy_out,
    output logic bus_grant_ack_n_out,
    output logic reg_access_allow_out
);
    // ------------------------------------------------------------
    // Decoder: external address while granted, CPU address otherwise
    // ------------------------------------------------------------
    csbm_dec_if dec ();
    logic grant_q, grant_d;
    assign dec.addr = grant_q ? ext_addr_in : cpu_addr_in;
    assign dec.io = grant_q ? !ext_io_req_n_in : cpu_io_in;

    csbm_cs_decode u_dec (
        .dec(dec),
        .cs_en_in(cs_en_in),
        .cs_io_in(cs_io_in),
        .cs_lower_in(cs_lower_in),
        .cs_upper_in(cs_upper_in)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    csbm_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d, len_q, len_d, hit_q, hit_d;
    logic [1:0] mode_q, mode_d, sel_mode;
    logic mux_q, mux_d, wr_q, wr_d, io_q, io_d, wait_q, last, start, seq, strb, four;
    logic [23:0] addr_q, addr_d;
    logic [7:0] wdata_q, wdata_d, rdata_d;
    logic done_d, busy_d, ack_n_d, allow_d, addr_oe_d, data_oe_d, rd_n_d, wr_n_d;
    logic mem_req_n_d, io_req_n_d, ale_d;
    logic [3:0] cs_n_d, sel_len;
    logic [7:0] data_d;

    assign sel_mode = cs_mode_in[{dec.idx, 1'b0} +: 2];
    assign sel_len = cs_len_in[{dec.idx, 2'b00} +: 4];
    assign start = cpu_req_in && !grant_q && dec.any
                   && (sel_mode == CSBM_MODE_THREE || sel_mode == CSBM_MODE_FOUR);
    assign last = (cnt_q == len_q - 4'h1);

    // ------------------------------------------------------------
    // Next state and outputs
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        len_d = len_q;
        mode_d = mode_q;
        mux_d = mux_q;
        wr_d = wr_q;
        io_d = io_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        hit_d = hit_q;
        grant_d = grant_q;
        rdata_d = cpu_rdata_out;
        done_d = 1'b0;
        unique case (st_q)
            ST_IDLE: begin
                if (grant_q) begin
                    grant_d = !bus_grant_request_n_in;
                end else if (start) begin
                    st_d = ST_T1;
                    cnt_d = CSBM_RST_CNT;
                    mode_d = sel_mode;
                    mux_d = cs_mux_in[dec.idx] && (sel_mode == CSBM_MODE_FOUR);
                    if (sel_mode == CSBM_MODE_FOUR) begin
                        len_d = (sel_len < CSBM_FOUR_MIN_LEN) ? CSBM_FOUR_MIN_LEN
                                                              : sel_len;
                    end else begin
                        len_d = (sel_len < CSBM_THREE_MIN_LEN) ? CSBM_THREE_MIN_LEN
                                                               : sel_len;
                    end
                    wr_d = cpu_wr_in;
                    io_d = cpu_io_in;
                    addr_d = cpu_addr_in;
                    wdata_d = cpu_wdata_in;
                    hit_d = dec.hit;
                end else if (!bus_grant_request_n_in) begin
                    // Grant only between cycles so a sequenced access is never cut
                    grant_d = 1'b1;
                end
            end
            ST_T1: begin
                cnt_d = last ? CSBM_RST_CNT : cnt_q + 4'h1;
                st_d = last ? ST_T2 : ST_T1;
            end
            ST_T2: begin
                cnt_d = last ? CSBM_RST_CNT : cnt_q + 4'h1;
                if (last) begin
                    // Sampled wait from one clock earlier gives the setup margin
                    st_d = wait_q ? ST_T3 : ST_TW;
                end
            end
            ST_TW: begin
                if (wait_n_in) begin
                    st_d = ST_T3;
                end
            end
            ST_T3: begin
                cnt_d = last ? CSBM_RST_CNT : cnt_q + 4'h1;
                if (last) begin
                    if (!wr_q) begin
                        rdata_d = bus_data_in;
                    end
                    if (mode_q == CSBM_MODE_FOUR) begin
                        st_d = ST_T4;
                    end else begin
                        st_d = ST_IDLE;
                        done_d = 1'b1;
                    end
                end
            end
            ST_T4: begin
                cnt_d = last ? CSBM_RST_CNT : cnt_q + 4'h1;
                if (last) begin
                    st_d = ST_IDLE;
                    done_d = 1'b1;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase

        seq = (st_d != ST_IDLE);
        strb = (st_d == ST_T2) || (st_d == ST_TW) || (st_d == ST_T3);
        four = (mode_d == CSBM_MODE_FOUR);
        busy_d = seq;
        ack_n_d = !grant_d;
        allow_d = !grant_d;
        ale_d = 1'b0;
        if (grant_q || grant_d) begin
            addr_d = addr_q;
            addr_oe_d = 1'b0;
            data_oe_d = 1'b0;
            data_d = CSBM_RST_DATA;
            rd_n_d = 1'b1;
            wr_n_d = 1'b1;
            mem_req_n_d = 1'b1;
            io_req_n_d = 1'b1;
            cs_n_d = CSBM_RST_CS_N;
            if (grant_q && (!ext_mem_req_n_in || !ext_io_req_n_in)) begin
                cs_n_d = ~dec.hit;
            end
        end else if (seq) begin
            addr_oe_d = 1'b1;
            cs_n_d = ~hit_d;
            rd_n_d = !(strb && !wr_d);
            wr_n_d = !(strb && wr_d);
            mem_req_n_d = !(strb && !io_d);
            io_req_n_d = !(strb && io_d);
            ale_d = four && (st_d == ST_T1) && (cnt_d < {1'b0, len_d[3:1]});
            if (mux_d && st_d == ST_T1) begin
                data_d = addr_d[7:0];
                data_oe_d = 1'b1;
            end else begin
                data_d = wdata_d;
                data_oe_d = wr_d;
            end
        end else begin
            // Native: CPU strobes and address are forwarded as they come
            addr_d = cpu_addr_in;
            addr_oe_d = 1'b1;
            data_d = cpu_wdata_in;
            data_oe_d = !cpu_wr_n_in;
            rd_n_d = cpu_rd_n_in;
            wr_n_d = cpu_wr_n_in;
            mem_req_n_d = cpu_mem_req_n_in;
            io_req_n_d = cpu_io_req_n_in;
            cs_n_d = CSBM_RST_CS_N;
            if ((!cpu_mem_req_n_in || !cpu_io_req_n_in) && !(sel_mode == CSBM_MODE_THREE
                                                      || sel_mode == CSBM_MODE_FOUR)) begin
                cs_n_d = ~dec.hit;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q <= ST_IDLE;
            cnt_q <= CSBM_RST_CNT;
            len_q <= CSBM_THREE_MIN_LEN;
            mode_q <= CSBM_MODE_NATIVE;
            mux_q <= 1'b0;
            wr_q <= 1'b0;
            io_q <= 1'b0;
            addr_q <= CSBM_RST_ADDR;
            wdata_q <= CSBM_RST_DATA;
            hit_q <= 4'h0;
            grant_q <= 1'b0;
            wait_q <= 1'b1;
            bus_addr_out <= CSBM_RST_ADDR;
            addr_oe_out <= 1'b0;
            bus_data_out <= CSBM_RST_DATA;
            data_oe_out <= 1'b0;
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
            memory_request_strobe_n_out <= 1'b1;
            io_request_strobe_n_out <= 1'b1;
            ale_out <= 1'b0;
            cs_n_out <= CSBM_RST_CS_N;
            cpu_rdata_out <= CSBM_RST_DATA;
            cpu_done_out <= 1'b0;
            cpu_busy_out <= 1'b0;
            bus_grant_ack_n_out <= 1'b1;
            reg_access_allow_out <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            mode_q <= mode_d;
            mux_q <= mux_d;
            wr_q <= wr_d;
            io_q <= io_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            hit_q <= hit_d;
            grant_q <= grant_d;
            wait_q <= wait_n_in;
            bus_addr_out <= addr_d;
            addr_oe_out <= addr_oe_d;
            bus_data_out <= data_d;
            data_oe_out <= data_oe_d;
            rd_n_out <= rd_n_d;
            wr_n_out <= wr_n_d;
            memory_request_strobe_n_out <= mem_req_n_d;
            io_request_strobe_n_out <= io_req_n_d;
            ale_out <= ale_d;
            cs_n_out <= cs_n_d;
            cpu_rdata_out <= rdata_d;
            cpu_done_out <= done_d;
            cpu_busy_out <= busy_d;
            bus_grant_ack_n_out <= ack_n_d;
            reg_access_allow_out <= allow_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_grant_release;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        !bus_grant_ack_n_out |-> !addr_oe_out && !data_oe_out && rd_n_out && wr_n_out;
    endproperty
    a_grant_release: assert property (p_grant_release) else $error("bus not released");

    property p_ext_cs;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        grant_q && !ext_mem_req_n_in && !bus_grant_request_n_in
        |=> cs_n_out == ~$past(dec.hit);
    endproperty
    a_ext_cs: assert property (p_ext_cs) else $error("external cs decode wrong");

    property p_no_reg;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        grant_q && !bus_grant_request_n_in |=> !reg_access_allow_out && !bus_grant_ack_n_out;
    endproperty
    a_no_reg: assert property (p_no_reg) else $error("register access during grant");

    property p_native;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        st_q == ST_IDLE && !start && !grant_q && bus_grant_request_n_in
        |=> rd_n_out == $past(cpu_rd_n_in) && wr_n_out == $past(cpu_wr_n_in);
    endproperty
    a_native: assert property (p_native) else $error("native pass-through broken");

    property p_len;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        st_q != ST_IDLE |-> cnt_q < len_q
            && len_q >= ((mode_q == CSBM_MODE_FOUR) ? CSBM_FOUR_MIN_LEN : CSBM_THREE_MIN_LEN);
    endproperty
    a_len: assert property (p_len) else $error("state length out of range");

    property p_t1;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        start && st_q == ST_IDLE
        |=> st_q == ST_T1 && cs_n_out == ~$past(dec.hit) && rd_n_out && wr_n_out;
    endproperty
    a_t1: assert property (p_t1) else $error("T1 outputs wrong");

    property p_t2_strobe;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        st_q == ST_T2 |-> (rd_n_out == wr_q) && (wr_n_out == !wr_q)
            && (memory_request_strobe_n_out == io_q);
    endproperty
    a_t2_strobe: assert property (p_t2_strobe) else $error("T2 strobes wrong");

    property p_wait;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        st_q == ST_T2 && last && !wait_q |=> st_q == ST_TW;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state not inserted");

    property p_rdata;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        st_q == ST_T3 && last && !wr_q |=> cpu_rdata_out == $past(bus_data_in);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data not captured");

    property p_mux;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        st_q == ST_T1 && mux_q |-> data_oe_out && bus_data_out == addr_q[7:0];
    endproperty
    a_mux: assert property (p_mux) else $error("low address not on data bus");

    property p_ale;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        st_q == ST_T1 && mode_q == CSBM_MODE_FOUR |-> ale_out == (cnt_q < {1'b0, len_q[3:1]});
    endproperty
    a_ale: assert property (p_ale) else $error("latch enable timing wrong");

    property p_t4;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        st_q == ST_T4 |-> rd_n_out && wr_n_out && cs_n_out == ~hit_q;
    endproperty
    a_t4: assert property (p_t4) else $error("T4 strobes wrong");
endmodule : csbm_top
`default_nettype wire

// ===== sim/csbm_periph_model.sv
// Behavioural external peripheral answering sequenced bus cycles
`timescale 1ns/1ps
`default_nettype none
module csbm_periph_model (
    input wire logic clk_sys_in,
    input wire logic rd_n_in,
    input wire logic [3:0] cs_n_in,
    input wire logic [23:0] addr_in,
    input wire logic [3:0] stall_in,
    output logic [7:0] data_out,
    output logic wait_n_out
);
    logic [3:0] cnt_q = 4'h0;
    logic sel_q = 1'b0;
    initial data_out = 8'h00;
    always @(posedge clk_sys_in) begin
        sel_q <= (cs_n_in != 4'hf);
        // Wait goes low from the second select cycle, well ahead of T2 and T3
        if ((cs_n_in != 4'hf) && !sel_q) cnt_q <= stall_in;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
        // A released bus toggles, so a late capture never sees a stale byte
        if (!rd_n_in && (cs_n_in != 4'hf)) data_out <= addr_in[7:0] ^ 8'h5a;
        else data_out <= ~data_out;
    end
    assign wait_n_out = (cnt_q == 4'h0);
endmodule : csbm_periph_model
`default_nettype wire

// ===== sim/csbm_top_tb.sv
// Self-checking testbench for the chip select bus mode sequencer
`timescale 1ns/1ps
`default_nettype none
module csbm_top_tb;
    import csbm_pkg::*;
    logic clk_sys_in, resetn_in, cpu_req_in, cpu_wr_in, cpu_io_in, cpu_rd_n_in, cpu_wr_n_in;
    logic cpu_mem_req_n_in, cpu_io_req_n_in, wait_n_in, bus_grant_request_n_in, ext_mem_req_n_in;
    logic ext_io_req_n_in, addr_oe_out, data_oe_out, rd_n_out, wr_n_out, ale_out, cpu_done_out;
    logic memory_request_strobe_n_out, io_request_strobe_n_out, cpu_busy_out;
    logic bus_grant_ack_n_out, reg_access_allow_out;
    logic [7:0] cs_mode_in, cpu_wdata_in, bus_data_in, bus_data_out, cpu_rdata_out;
    logic [3:0] cs_mux_in, cs_en_in, cs_io_in, cs_n_out, stall;
    logic [15:0] cs_len_in;
    logic [31:0] cs_lower_in, cs_upper_in;
    logic [23:0] cpu_addr_in, ext_addr_in, bus_addr_out;
    int fail_count = 0;
    int check_count = 0;
    csbm_top dut (.clk_sys_in, .resetn_in, .cs_mode_in, .cs_mux_in, .cs_len_in, .cs_en_in,
        .cs_io_in, .cs_lower_in, .cs_upper_in, .cpu_req_in, .cpu_wr_in, .cpu_io_in,
        .cpu_addr_in, .cpu_wdata_in, .cpu_rd_n_in, .cpu_wr_n_in, .cpu_mem_req_n_in,
        .cpu_io_req_n_in, .wait_n_in, .bus_data_in, .bus_grant_request_n_in, .ext_addr_in,
        .ext_mem_req_n_in, .ext_io_req_n_in, .bus_addr_out, .addr_oe_out, .bus_data_out,
        .data_oe_out, .rd_n_out, .wr_n_out, .memory_request_strobe_n_out,
        .io_request_strobe_n_out, .ale_out, .cs_n_out, .cpu_rdata_out, .cpu_done_out,
        .cpu_busy_out, .bus_grant_ack_n_out, .reg_access_allow_out);
    csbm_periph_model peer (.clk_sys_in, .rd_n_in(rd_n_out), .cs_n_in(cs_n_out),
        .addr_in(bus_addr_out), .stall_in(stall), .data_out(bus_data_in),
        .wait_n_out(wait_n_in));
    // ------------------------------------------------------------
    // Shared checks and closing report
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic results();
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_native();
        @(posedge clk_sys_in);
        cpu_addr_in <= 24'h123456;
        cpu_rd_n_in <= 1'b0;
        cpu_mem_req_n_in <= 1'b0;
        cpu_req_in <= 1'b1;
        @(posedge clk_sys_in);
        cpu_req_in <= 1'b0;
        @(negedge clk_sys_in);
        chk("nat_rd", rd_n_out, 1'b0);
        chk("nat_mem", memory_request_strobe_n_out, 1'b0);
        chk("nat_cs", cs_n_out, 4'he);
        chk("nat_addr", bus_addr_out, 24'h123456);
        chk("nat_busy", cpu_busy_out, 1'b0);
        @(posedge clk_sys_in);
        cpu_rd_n_in <= 1'b1;
        cpu_mem_req_n_in <= 1'b1;
    endtask : t_native
    // One sequenced cycle on cs0 (memory) or cs1 (I/O); the other cs is set apart
    task automatic bus_cycle(input logic [1:0] md, input logic mx, wr, io,
                             input logic [3:0] ln, st);
        logic [23:0] a;
        logic st_n;
        int n, ls, ns, ex;
        a = io ? 24'h001234 : 24'h3456c7;
        ns = (md == CSBM_MODE_FOUR) ? 4 : 3;
        ls = (ns == 4) ? ((ln < 2) ? 2 : ln) : ((ln < 1) ? 1 : ln);
        ex = ns * ls + 1;
        n = 0;
        @(posedge clk_sys_in);
        stall <= st;
        cs_mode_in <= io ? {4'h0, md, 2'h3} : {4'h0, 2'h3, md};
        cs_len_in <= io ? {8'hff, ln, 4'hf} : {12'hfff, ln};
        cs_mux_in <= {2'h0, mx, mx};
        cpu_wr_in <= wr;
        cpu_io_in <= io;
        cpu_addr_in <= a;
        cpu_wdata_in <= 8'ha5;
        cpu_req_in <= 1'b1;
        @(posedge clk_sys_in);
        cpu_req_in <= 1'b0;
        do begin
            @(negedge clk_sys_in);
            n++;
            st_n = wr ? wr_n_out : rd_n_out;
            if (n > 80) begin
                chk("timeout", 1'b0, 1'b1);
                results();
            end
            if (n == 1) begin
                chk("t1_cs", cs_n_out[io], 1'b0);
                chk("t1_addr", bus_addr_out, a);
                chk("t1_aoe", addr_oe_out, 1'b1);
                chk("t1_busy", cpu_busy_out, 1'b1);
                if (ns == 4) chk("t1_ale", ale_out, 1'b1);
                if (ns == 4 && mx) chk("t1_mux", bus_data_out, a[7:0]);
                if (ns == 4 && !mx && !wr) chk("t1_oe", data_oe_out, 1'b0);
            end
            if (ns == 4 && n == ls) chk("ale_low", ale_out, 1'b0);
            if (n == ls + 1) begin
                chk("t2_strobe", st_n, 1'b0);
                chk("t2_mem", memory_request_strobe_n_out, io);
                chk("t2_io", io_request_strobe_n_out, !io);
                if (ns == 4 && wr) chk("t2_wdata", bus_data_out, 8'ha5);
            end
            if (st == 0 && n == 3 * ls) chk("t3_hold", st_n, 1'b0);
            if (st == 0 && ns == 4 && n == ex - ls) chk("t4_rd", st_n, 1'b1);
        end while (cpu_done_out !== 1'b1);
        if (st == 0) chk("done_at", n, ex);
        else chk("waited", (n > ex) && (n < ex + st + 4), 1'b1);
        if (!wr) chk("rdata", cpu_rdata_out, a[7:0] ^ 8'h5a);
    endtask : bus_cycle
    task automatic t_grant();
        @(posedge clk_sys_in);
        cs_mode_in <= 8'h01;
        bus_grant_request_n_in <= 1'b0;
        ext_addr_in <= 24'h3456c7;
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk("ack", bus_grant_ack_n_out, 1'b0);
        chk("addr_oe", addr_oe_out, 1'b0);
        chk("data_oe", data_oe_out, 1'b0);
        chk("allow", reg_access_allow_out, 1'b0);
        @(posedge clk_sys_in);
        ext_mem_req_n_in <= 1'b0;
        cpu_req_in <= 1'b1;
        @(posedge clk_sys_in);
        cpu_req_in <= 1'b0;
        @(negedge clk_sys_in);
        chk("ext_cs", cs_n_out, 4'he);
        chk("g_busy", cpu_busy_out, 1'b0);
        @(posedge clk_sys_in);
        ext_mem_req_n_in <= 1'b1;
        bus_grant_request_n_in <= 1'b1;
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk("ack_rel", bus_grant_ack_n_out, 1'b1);
        chk("allow_rel", reg_access_allow_out, 1'b1);
    endtask : t_grant
    // ------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        {resetn_in, cpu_req_in, cpu_wr_in, cpu_io_in, cs_mode_in, cs_mux_in, cs_len_in} = '0;
        {cpu_rd_n_in, cpu_wr_n_in, cpu_mem_req_n_in, cpu_io_req_n_in} = 4'hf;
        {bus_grant_request_n_in, ext_mem_req_n_in, ext_io_req_n_in} = 3'h7;
        cpu_addr_in = 24'h000000;
        ext_addr_in = 24'h000000;
        cpu_wdata_in = 8'h00;
        stall = 4'h0;
        cs_en_in = 4'h3;
        cs_io_in = 4'h2;
        cs_lower_in = 32'h00001200;
        cs_upper_in = 32'h000000ff;
        repeat (10) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk("rst_cs", cs_n_out, CSBM_RST_CS_N);
        chk("rst_ack", bus_grant_ack_n_out, 1'b1);
        chk("rst_oe", addr_oe_out, 1'b0);
        @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        t_native();
        bus_cycle(CSBM_MODE_THREE, 1'b0, 1'b0, 1'b0, 4'h1, 4'h0);
        bus_cycle(CSBM_MODE_THREE, 1'b0, 1'b1, 1'b1, 4'hf, 4'h0);
        bus_cycle(CSBM_MODE_THREE, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0);
        bus_cycle(CSBM_MODE_THREE, 1'b0, 1'b0, 1'b0, 4'h2, 4'h3);
        bus_cycle(CSBM_MODE_FOUR, 1'b1, 1'b0, 1'b0, 4'h2, 4'h0);
        bus_cycle(CSBM_MODE_FOUR, 1'b1, 1'b1, 1'b1, 4'h3, 4'h0);
        bus_cycle(CSBM_MODE_FOUR, 1'b0, 1'b0, 1'b0, 4'h1, 4'h0);
        bus_cycle(CSBM_MODE_FOUR, 1'b0, 1'b1, 1'b0, 4'h2, 4'h3);
        t_grant();
        results();
    end
endmodule : csbm_top_tb
`default_nettype wire
